//--- hdl/wlc_fb_if.sv
// Feedback carrier between the top and one byte-lane sampler.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface wlc_fb_if;
  logic arm;
  logic fb;
  logic seen;
  modport top (output arm, input fb, input seen);
  modport smp (input arm, output fb, output seen);
endinterface : wlc_fb_if

//--- hdl/wlc_map.svh
// Named constants of the write-leveling and chip-select latency block.
// Assumes inclusion by its bare name from the package and the top.
`ifndef WLC_MAP_SVH
`define WLC_MAP_SVH

// ============================================================
// Mode-register selection and field positions
`define WLC_MR_LVL     3'h1
`define WLC_MR_CAL     3'h4
`define WLC_A_WL       7
`define WLC_A_QOFF     12
`define WLC_CAL_LSB    6
`define WLC_CAL_MSB    8

// ============================================================
// Latency field encodings and their clock counts
`define WLC_CAL_OFF    3'h0
`define WLC_CAL_E3     3'h1
`define WLC_CAL_E4     3'h2
`define WLC_CAL_E5     3'h3
`define WLC_CAL_E6     3'h4
`define WLC_CAL_E8     3'h5
`define WLC_NCK_0      4'h0
`define WLC_NCK_3      4'h3
`define WLC_NCK_4      4'h4
`define WLC_NCK_5      4'h5
`define WLC_NCK_6      4'h6
`define WLC_NCK_8      4'h8

// ============================================================
// Timing: mode-register-set delay is max(24 clocks, 15 ns)
`define WLC_TCK_NS     10
`define WLC_TMOD_NS    15
`define WLC_TMOD_NCK   24
`define WLC_TMOD_NSCYC ((`WLC_TMOD_NS + `WLC_TCK_NS - 1) / `WLC_TCK_NS)
`define WLC_TMOD_CYC   ((`WLC_TMOD_NSCYC > `WLC_TMOD_NCK) ? \
                         `WLC_TMOD_NSCYC : `WLC_TMOD_NCK)

`endif

//--- hdl/wlc_pkg.sv
// Types and helpers of the write-leveling and chip-select latency block.
// Assumes the constant header sits beside it.
`include "wlc_map.svh"

package wlc_pkg;

  // ============================================================
  // Leveling state, Gray coded along off, settle, run, exit
  typedef enum logic [1:0] {
    WLC_OFF    = 2'h0,
    WLC_SETTLE = 2'h1,
    WLC_RUN    = 2'h3,
    WLC_EXIT   = 2'h2
  } wlc_state_e;

  typedef logic [3:0] wlc_nck_t;

  function automatic wlc_nck_t wlc_cal_nck(input logic [2:0] code);
    case (code)
      `WLC_CAL_E3: wlc_cal_nck = `WLC_NCK_3;
      `WLC_CAL_E4: wlc_cal_nck = `WLC_NCK_4;
      `WLC_CAL_E5: wlc_cal_nck = `WLC_NCK_5;
      `WLC_CAL_E6: wlc_cal_nck = `WLC_NCK_6;
      `WLC_CAL_E8: wlc_cal_nck = `WLC_NCK_8;
      default:     wlc_cal_nck = `WLC_NCK_0;
    endcase
  endfunction : wlc_cal_nck

endpackage : wlc_pkg

//--- hdl/wlc_sampler.sv
// One byte-lane leveling sampler: catches the clock level at strobe rise.
// Assumes strobe and sampled clock level are asynchronous to clk.
`timescale 1ns/10ps

module wlc_sampler
  import wlc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic dqs_raw,
  input wire logic ck_raw,
  wlc_fb_if.smp    fb
);

  logic dqs_s1_q, dqs_s2_q, dqs_s3_q;
  logic ck_s1_q,  ck_s2_q;
  logic fb_q,     seen_q;
  logic rise;

  // ============================================================
  // Synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dqs_s1_q <= 1'b0;
      dqs_s2_q <= 1'b0;
      dqs_s3_q <= 1'b0;
      ck_s1_q  <= 1'b0;
      ck_s2_q  <= 1'b0;
    end else begin
      dqs_s1_q <= dqs_raw;
      dqs_s2_q <= dqs_s1_q;
      dqs_s3_q <= dqs_s2_q;
      ck_s1_q  <= ck_raw;
      ck_s2_q  <= ck_s1_q;
    end
  end

  assign rise = dqs_s2_q & ~dqs_s3_q;

  // ============================================================
  // Sample capture
  // The real part answers without a clock; here the answer lags the
  // strobe by the synchroniser depth, which stays within the output delay.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fb_q   <= 1'b0;
      seen_q <= 1'b0;
    end else if (!fb.arm) begin
      seen_q <= 1'b0;
    end else if (rise) begin
      fb_q   <= ck_s2_q;
      seen_q <= 1'b1;
    end
  end

  assign fb.fb   = fb_q;
  assign fb.seen = seen_q;

  sample_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rise && fb.arm) |=> (fb.fb == $past(ck_s2_q)) && fb.seen)
    else $error("feedback does not hold the sampled clock level");

endmodule : wlc_sampler

//--- hdl/wlc_top.sv
// Write-leveling mode and chip-select-to-command latency, device side.
// Assumes command pins are sampled on clk; strobes and ck_smp are not.
//
// Overview of operation
// - Mode write bit A7 enters/exits leveling.
// - Bit A12 set disables data outputs.
// - In leveling, ODT switches only strobe termination.
// - Data outputs undefined after leveling entry.
// - Exit write also applies other bits.
// - ODT accepted only after mode delay.
// - Mode delay is max(24 clocks, 15 ns), plus the latency in force.
// - Strobe termination applied before strobe enable.
// - Strobe rise samples clock onto data.
// - No read strobes with leveling feedback.
// - Data undefined until mode delay after exit.
// - Command taken latency clocks after chip-select.
// - Receivers sleep after command, stay for bursts.
// - Each byte lane reports its own feedback.
`timescale 1ns/10ps

`include "wlc_map.svh"

module wlc_top
  import wlc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cs_n,
  input  wire logic        cmd_mrs,
  input  wire logic [2:0]  cmd_mr,
  input  wire logic [13:0] cmd_addr,
  input  wire logic        odt,
  input  wire logic        dqs_l,
  input  wire logic        dqs_u,
  input  wire logic        ck_smp,
  output logic             wl_active,
  output logic             qoff,
  output logic [13:0]      mr1_val,
  output logic [3:0]       cal_nck,
  output logic             ca_rx_en,
  output logic             cmd_take,
  output logic             mrs_ready,
  output logic             odt_accept,
  output logic             dqs_term_en,
  output logic             dq_term_en,
  output logic             park_sel,
  output logic             rd_dqs_oe,
  output logic             dq_undef,
  output logic [15:0]      dq_out,
  output logic [15:0]      dq_oe
);

  localparam int TMODC = `WLC_TMOD_CYC;

  wlc_state_e  state_q, state_d;
  logic [13:0] mr1_q;
  wlc_nck_t    cal_q, cal_new;
  logic [7:0]  hist_q, take_mask, pend_mask;
  logic [5:0]  mod_cnt_q;
  logic        take_mrs, take_mr1, take_cal, wl_bit;

  wlc_fb_if fb_lo ();
  wlc_fb_if fb_hi ();

  // ============================================================
  // Chip-select latency and command capture
  // A chip-select low is remembered in a history line; with latency N
  // the command pins are read N clocks later.
  assign take_mask = 8'(9'h1 << (cal_q - 4'h1));
  assign pend_mask = 8'((9'h1 << cal_q) - 9'h1);
  assign cmd_take  = (cal_q == `WLC_NCK_0) ? !cs_n
                                           : |(hist_q & take_mask);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_q <= 8'h0;
    end else begin
      hist_q <= {hist_q[6:0], !cs_n};
    end
  end

  // Receivers wake on chip-select and stay up while any command is due.
  assign ca_rx_en = (cal_q == `WLC_NCK_0) || !cs_n
                    || |(hist_q & pend_mask);

  assign take_mrs = cmd_take && cmd_mrs;
  assign take_mr1 = take_mrs && (cmd_mr == `WLC_MR_LVL);
  assign take_cal = take_mrs && (cmd_mr == `WLC_MR_CAL);
  assign wl_bit   = cmd_addr[`WLC_A_WL];
  assign cal_new  = take_cal
                  ? wlc_cal_nck(cmd_addr[`WLC_CAL_MSB:`WLC_CAL_LSB])
                  : cal_q;

  // ============================================================
  // Mode registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mr1_q <= 14'h0;
    end else if (take_mr1) begin
      mr1_q <= cmd_addr;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_q <= `WLC_NCK_0;
    end else begin
      cal_q <= cal_new;
    end
  end

  assign mr1_val = mr1_q;
  assign qoff    = mr1_q[`WLC_A_QOFF];
  assign cal_nck = cal_q;

  // ============================================================
  // Mode-register-set delay, stretched by the latency in force
  // A write that changes the latency already counts with the new value.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mod_cnt_q <= 6'h0;
    end else if (take_mrs) begin
      mod_cnt_q <= 6'(TMODC) + {2'h0, cal_new};
    end else if (mod_cnt_q != 6'h0) begin
      mod_cnt_q <= mod_cnt_q - 6'h1;
    end
  end

  assign mrs_ready = (mod_cnt_q == 6'h0);

  // ============================================================
  // Leveling state
  always_comb begin
    state_d = state_q;
    case (state_q)
      WLC_OFF: begin
        if (take_mr1 && wl_bit) state_d = WLC_SETTLE;
      end
      WLC_SETTLE: begin
        if (take_mr1 && !wl_bit) state_d = WLC_EXIT;
        else if (mrs_ready) state_d = WLC_RUN;
      end
      WLC_RUN: begin
        if (take_mr1 && !wl_bit) state_d = WLC_EXIT;
      end
      WLC_EXIT: begin
        if (take_mr1 && wl_bit) state_d = WLC_SETTLE;
        else if (mrs_ready) state_d = WLC_OFF;
      end
      default: state_d = WLC_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= WLC_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  assign wl_active  = (state_q == WLC_SETTLE) || (state_q == WLC_RUN);
  assign odt_accept = (state_q == WLC_RUN);

  // ============================================================
  // Termination
  // Strobe termination stays on in leveling, nominal or park by ODT;
  // data termination is held off so the feedback is not loaded.
  assign dqs_term_en = wl_active;
  assign park_sel    = !(odt_accept && odt);
  assign dq_term_en  = !wl_active && odt;

  // ============================================================
  // Byte-lane feedback
  assign fb_lo.arm = odt_accept;
  assign fb_hi.arm = odt_accept;

  wlc_sampler u_smp_lo (
    .clk     (clk),
    .reset_n (reset_n),
    .dqs_raw (dqs_l),
    .ck_raw  (ck_smp),
    .fb      (fb_lo)
  );

  wlc_sampler u_smp_hi (
    .clk     (clk),
    .reset_n (reset_n),
    .dqs_raw (dqs_u),
    .ck_raw  (ck_smp),
    .fb      (fb_hi)
  );

  // Read strobes are never driven while the feedback is on the bus.
  assign rd_dqs_oe = 1'b0;
  assign dq_undef  = (state_q == WLC_SETTLE) || (state_q == WLC_EXIT)
                     || (odt_accept && !(fb_lo.seen && fb_hi.seen));
  assign dq_out    = {{8{fb_hi.fb}}, {8{fb_lo.fb}}};
  assign dq_oe     = {16{(state_q != WLC_OFF) && !qoff}};

  // ============================================================
  // Checks
  wl_enter_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == WLC_OFF && take_mr1 && wl_bit) |=> wl_active)
    else $error("leveling not entered on mode write");

  wl_exit_a: assert property (@(posedge clk) disable iff (!reset_n)
    (wl_active && take_mr1 && !wl_bit) |=> (state_q == WLC_EXIT))
    else $error("leveling not left on mode write");

  exit_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
    (take_mr1 && !wl_bit) |=> (mr1_val == $past(cmd_addr)))
    else $error("exit write did not apply other bits");

  qoff_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    qoff |-> (dq_oe == 16'h0))
    else $error("outputs driven while disabled");

  term_lvl_a: assert property (@(posedge clk) disable iff (!reset_n)
    wl_active |-> (dqs_term_en && !dq_term_en))
    else $error("wrong termination in leveling");

  mod_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_mrs |=> (mod_cnt_q >= 6'(TMODC)))
    else $error("mode delay shorter than minimum");

  sequence s_entry;
    state_q == WLC_OFF ##1 state_q == WLC_SETTLE;
  endsequence

  odt_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_entry |-> (!odt_accept && dq_undef)[*8])
    else $error("ODT accepted before mode delay");

  no_strobe_a: assert property (@(posedge clk) disable iff (!reset_n)
    wl_active |-> !rd_dqs_oe)
    else $error("read strobe driven in leveling");

  exit_undef_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == WLC_EXIT) |-> (dq_undef && !mrs_ready || state_d == WLC_OFF
                               || take_mr1))
    else $error("data defined before exit delay");

  cal_three_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!cs_n && cal_q == `WLC_NCK_3) |-> ##3 (cmd_take || cal_q != `WLC_NCK_3))
    else $error("command not taken three clocks after select");

  rx_awake_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!cs_n && cal_q != `WLC_NCK_0) |=> ca_rx_en)
    else $error("receivers asleep with command due");

  lane_map_a: assert property (@(posedge clk) disable iff (!reset_n)
    (odt_accept && fb_lo.seen) |-> (dq_out[0] == fb_lo.fb
                                    && dq_out[15] == fb_hi.fb))
    else $error("lane feedback misrouted");

endmodule : wlc_top

//--- tb/wlc_host.sv
// Host controller model: issues mode writes, drives ODT, strobes, clock.
// Assumes each task is entered right after a rising edge of clk.
`timescale 1ns/10ps

module wlc_host (
  input  wire logic  clk,
  output logic       cs_n,
  output logic       cmd_mrs,
  output logic [2:0] cmd_mr,
  output logic [13:0] cmd_addr,
  output logic       odt,
  output logic       dqs_l,
  output logic       dqs_u,
  output logic       ck_smp
);
  // ============================================================
  // Idle pins
  initial begin
    cs_n     = 1'b1;
    cmd_mrs  = 1'b0;
    cmd_mr   = 3'h0;
    cmd_addr = 14'h0000;
    odt      = 1'b0;
    dqs_l    = 1'b0;
    dqs_u    = 1'b0;
    ck_smp   = 1'b0;
  end

  // ============================================================
  // Mode write; the command is held until the latency has run out.
  // Only mode writes are ever issued, never other commands.
  task automatic mrs(input logic [2:0] mr, input logic [13:0] a,
                     input int n);
    cs_n     <= 1'b0;
    cmd_mrs  <= 1'b1;
    cmd_mr   <= mr;
    cmd_addr <= a;
    @(posedge clk);
    cs_n <= 1'b1;
    repeat (n) @(posedge clk);
    cmd_mrs  <= 1'b0;
    cmd_mr   <= ~mr;
    cmd_addr <= ~a;
  endtask : mrs

  // ============================================================
  // ODT change; the wait leaves margin for termination turn-on.
  // Only nominal or park is ever selected, never write termination.
  task automatic odt_set(input logic v);
    odt <= v;
    repeat (4) @(posedge clk);
  endtask : odt_set

  // A single rising strobe edge on each lane whose flag (l, u) is set, then back low.
  task automatic pulse(input logic l, input logic u, input logic ck);
    ck_smp <= ck;
    repeat (2) @(posedge clk);
    dqs_l <= l;
    dqs_u <= u;
    repeat (4) @(posedge clk);
    dqs_l <= 1'b0;
    dqs_u <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse
endmodule : wlc_host

//--- tb/wlc_top_tb.sv
// Self-checking bench of the leveling and chip-select latency block.
// Assumes the host model drives every command, strobe and ODT pin.
`timescale 1ns/10ps

module wlc_top_tb;
  int          num_errors;
  int          n_checks;
  int          n_cal;
  int          nck[6] = '{0, 3, 4, 5, 6, 8};
  logic        clk;
  logic        reset_n;
  logic        cs_n, cmd_mrs, odt, dqs_l, dqs_u, ck_smp;
  logic [2:0]  cmd_mr;
  logic [13:0] cmd_addr, mr1_val;
  logic [3:0]  cal_nck;
  logic        wl_active, qoff, ca_rx_en, cmd_take, mrs_ready;
  logic        odt_accept, dqs_term_en, dq_term_en, park_sel;
  logic        rd_dqs_oe, dq_undef;
  logic [15:0] dq_out, dq_oe;

  wlc_top DUT (.clk, .reset_n, .cs_n, .cmd_mrs, .cmd_mr, .cmd_addr, .odt,
    .dqs_l, .dqs_u, .ck_smp, .wl_active, .qoff, .mr1_val, .cal_nck,
    .ca_rx_en, .cmd_take, .mrs_ready, .odt_accept, .dqs_term_en,
    .dq_term_en, .park_sel, .rd_dqs_oe, .dq_undef, .dq_out, .dq_oe);

  wlc_host host (.clk, .cs_n, .cmd_mrs, .cmd_mr, .cmd_addr, .odt,
    .dqs_l, .dqs_u, .ck_smp);

  // ============================================================
  // Clock, comparison and verdict
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ============================================================
  // Access tasks
  task automatic issue(input logic [2:0] mr, input logic [13:0] a);
    @(posedge clk);
    fork
      host.mrs(mr, a, n_cal);
      begin
        @(negedge clk);
        chk(ca_rx_en, 1'b1, "rx awake");
        repeat (n_cal) @(negedge clk);
        chk(cmd_take, 1'b1, "take");
      end
    join
  endtask : issue

  // Entered at a negedge; counts cycles with the mode delay running.
  task automatic settle(input int exp);
    int n;
    n = 0;
    while (mrs_ready !== 1'b1 && n < 300) begin
      n++;
      @(negedge clk);
    end
    chk(n[15:0], exp[15:0], "mode delay");
  endtask : settle

  // ============================================================
  // Tests
  initial begin
    num_errors = 0;
    n_checks   = 0;
    n_cal      = 0;
    reset_n    = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk({wl_active, qoff, mrs_ready, ca_rx_en, rd_dqs_oe, park_sel},
        16'h000d, "reset");
    chk(dq_oe, 16'h0000, "reset drive");
    for (int c = 5; c >= 1; c--) begin
      issue(3'h4, 14'(c) << 6);
      n_cal = nck[c];
      @(negedge clk);
      chk(16'(cal_nck), 16'(nck[c]), "latency");
      settle(24 + nck[c]);
      chk(ca_rx_en, 1'b0, "rx asleep");
    end
    issue(3'h1, 14'h0080);
    @(negedge clk);
    chk({wl_active, dq_undef, dqs_term_en, dq_term_en, odt_accept},
        16'h001c, "entry");
    chk(dq_oe, 16'hffff, "entry drive");
    settle(24 + n_cal);
    chk(odt_accept, 1'b0, "odt early");
    @(negedge clk);
    chk(odt_accept, 1'b1, "odt accept");
    @(posedge clk);
    host.odt_set(1'b1);
    @(negedge clk);
    chk({dq_term_en, dqs_term_en, park_sel}, 16'h0002, "nominal");
    @(posedge clk);
    host.pulse(1'b1, 1'b0, 1'b1);
    host.pulse(1'b0, 1'b1, 1'b0);
    @(negedge clk);
    chk(dq_out, 16'h00ff, "lanes");
    chk({dq_undef, rd_dqs_oe}, 16'h0000, "feedback");
    @(posedge clk);
    host.pulse(1'b1, 1'b1, 1'b0);
    @(negedge clk);
    chk(dq_out, 16'h0000, "sweep low");
    @(posedge clk);
    host.pulse(1'b1, 1'b1, 1'b1);
    @(negedge clk);
    chk(dq_out, 16'hffff, "sweep high");
    issue(3'h1, 14'h1080);
    @(negedge clk);
    chk({wl_active, qoff}, 16'h0003, "qoff");
    chk(dq_oe, 16'h0000, "qoff drive");
    settle(24 + n_cal);
    @(posedge clk);
    host.odt_set(1'b0);
    @(negedge clk);
    chk({dqs_term_en, dq_term_en, park_sel}, 16'h0005, "park");
    issue(3'h1, 14'h0002);
    @(negedge clk);
    chk(mr1_val, 16'h0002, "exit bits");
    chk({wl_active, qoff, dq_undef}, 16'h0001, "exit");
    settle(24 + n_cal);
    @(negedge clk);
    chk({dq_undef, dq_oe}, 16'h0000, "off");
    print_verdict();
  end

  // Watchdog; the tests need well under ten microseconds.
  initial begin
    #30us;
    num_errors++;
    $display("unexpected at %0t: watchdog", $time);
    print_verdict();
  end
endmodule : wlc_top_tb
